// file: sim/i2cr_host_model.sv
`default_nettype none

module i2cr_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // bus host: makes every clock pulse, stands still when idle
  // ---------------------------------------------------------------
  int lowExtra = 0;

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one bit: data set in low phase, sampled in high phase
  task bitIo(input logic b, output logic s);
    tick(4 + lowExtra);
    sdaLow <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    s = sda;
    tick(4);
    scl <= 1'b0;
  endtask : bitIo

  // plain and repeated start look the same on the wire
  task startCond;
    tick(4);
    sdaLow <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : startCond

  task stopCond;
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(8);
  endtask : stopCond

  // whole byte msb first, ninth pulse carries the acknowledge
  task xfer(input logic [7:0] d, input logic hostAck,
            output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], s);
      rx[i] = s;
    end
    bitIo(~hostAck, s);
    ack = ~s;
  endtask : xfer
endmodule : i2cr_host_model

`default_nettype wire

// file: sim/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary bus address
  logic clk, arst_n, scl, hostLow, deviceReady, sdaOe_n, busy, ack;
  logic sdaIn, sdaOut;
  logic [7:0] regRdData, regAddr, cfg0, cfg1, rx;
  i2cr_pkg::i2cr_regreq_s regReq;
  logic [15:0] reqQ[$];
  int num_errors = 0;
  int comparisons = 0;

  assign sdaIn = hostLow ? 1'b0 : (sdaOe_n === 1'b0 ? sdaOut : 1'b1);
  assign regRdData = regAddr ^ 8'h5C;

  i2cr_client_port #(.CLIENT_ADDR(ADDR)) u_dut (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sdaIn(sdaIn),
    .deviceReady(deviceReady), .regRdData(regRdData), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .busy(busy), .regAddr(regAddr),
    .regReq(regReq), .sourceSlot0Config(cfg0),
    .sourceSlot1Config(cfg1)
  );

  i2cr_host_model u_host (
    .clk(clk), .sda(sdaIn), .scl(scl), .sdaLow(hostLow)
  );

  always @(posedge clk) begin
    if (regReq.wr === 1'b1) begin
      reqQ.push_back({regReq.addr, regReq.data});
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk8(input logic [7:0] got, input logic [7:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk8

  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task setPtr(input logic [7:0] ptr);
    u_host.startCond();
    u_host.xfer({ADDR, 1'b0}, 1'b0, rx, ack);
    chk8({7'h00, ack}, 8'h01, "addr ack");
    chk8({7'h00, busy}, 8'h01, "busy");
    u_host.xfer(ptr, 1'b0, rx, ack);
    chk8({7'h00, ack}, 8'h01, "ptr ack");
  endtask : setPtr

  task wrByte(input logic [7:0] d);
    u_host.xfer(d, 1'b0, rx, ack);
    chk8({7'h00, ack}, 8'h01, "data ack");
  endtask : wrByte

  task stopBus;
    u_host.stopCond();
    chk8({7'h00, busy}, 8'h00, "busy after stop");
  endtask : stopBus

  function automatic logic [7:0] nextA(input logic [7:0] a, input int m);
    if (m == 1 && a == 8'h63) return 8'h61;
    if (m == 2 && a == 8'h65) return 8'h61;
    if (m == 3 && a == 8'h69) return 8'h61;
    return a + 8'h01;
  endfunction : nextA

  // write both wrap enables from mode bits m[0] and m[1], read them back, then read three bytes
  task wrapMode(input int m, input logic [7:0] start);
    logic [7:0] a;
    a = start;
    setPtr(8'h1A);
    wrByte({m[0], 7'h00});
    wrByte({m[1], 7'h00});
    stopBus();
    chk8(cfg0, {m[0], 7'h00}, "slot0 cfg");
    chk8(cfg1, {m[1], 7'h00}, "slot1 cfg");
    setPtr(8'h1A);
    u_host.startCond();
    u_host.xfer({ADDR, 1'b1}, 1'b0, rx, ack);
    u_host.xfer(8'hFF, 1'b1, rx, ack);
    chk8(rx, {m[0], 7'h00}, "slot0 readback");
    u_host.xfer(8'hFF, 1'b0, rx, ack);
    chk8(rx, {m[1], 7'h00}, "slot1 readback");
    stopBus();
    setPtr(start);
    u_host.startCond();
    u_host.xfer({ADDR, 1'b1}, 1'b0, rx, ack);
    chk8({7'h00, ack}, 8'h01, "read addr ack");
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(8'hFF, i < 2, rx, ack);
      chk8(rx, a ^ 8'h5C, "read data");
      if (i < 2) a = nextA(a, m);
    end
    stopBus();
    chk8(regAddr, a, "ptr after nack");
    $display("test wrap mode %0d done", m);
  endtask : wrapMode

  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    arst_n <= 1'b0;
    deviceReady <= 1'b1;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk8({7'h00, sdaOe_n}, 8'h01, "sda released");
    chk8({7'h00, sdaOut}, 8'h00, "drive level");
    chk8({7'h00, busy}, 8'h00, "busy idle");
    chk8(regAddr, 8'h00, "ptr reset");
    chk8({7'h00, regReq.wr}, 8'h00, "no write");
    chk8(cfg0, 8'h00, "cfg0 reset");
    chk8(cfg1, 8'h00, "cfg1 reset");
    $display("test reset done");
    u_host.startCond();
    u_host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b0, rx, ack);
    chk8({7'h00, ack}, 8'h00, "foreign addr");
    u_host.startCond();
    u_host.xfer({ADDR ^ 7'h01, 1'b1}, 1'b0, rx, ack);
    chk8({7'h00, ack}, 8'h00, "foreign restart");
    stopBus();
    @(posedge clk);
    deviceReady <= 1'b0;
    u_host.startCond();
    u_host.xfer({ADDR, 1'b0}, 1'b0, rx, ack);
    chk8({7'h00, ack}, 8'h00, "not ready");
    stopBus();
    deviceReady <= 1'b1;
    $display("test nack done");
    reqQ.delete();
    setPtr(8'hFF);
    wrByte(8'h11);
    wrByte(8'h22);
    stopBus();
    chk8(8'(reqQ.size()), 8'h02, "write count");
    chk8(reqQ[0][15:8], 8'hFF, "wr addr 0");
    chk8(reqQ[0][7:0], 8'h11, "wr data 0");
    chk8(reqQ[1][15:8], 8'h00, "wr addr 1");
    chk8(reqQ[1][7:0], 8'h22, "wr data 1");
    chk8(regAddr, 8'h01, "ptr after write");
    $display("test write done");
    wrapMode(0, 8'hFE);
    wrapMode(1, 8'h62);
    wrapMode(2, 8'h64);
    u_host.lowExtra = 12;
    wrapMode(3, 8'h68);
    end_sim();
  end
endmodule : tb_top

`default_nettype wire

// file: verilog/i2cr_client_port.sv
`default_nettype none

module i2cr_client_port #(
  // bus address of this client; value is arbitrary
  parameter logic [6:0] CLIENT_ADDR = 7'h2A
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic deviceReady,
  input wire logic [7:0] regRdData,
  output logic sdaOut,
  output logic sdaOe_n,
  output logic busy,
  output logic [7:0] regAddr,
  output i2cr_pkg::i2cr_regreq_s regReq,
  output logic [7:0] sourceSlot0Config,
  output logic [7:0] sourceSlot1Config
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic sclMeta_ff, sclSync_ff, sclDly_ff;
  logic sdaMeta_ff, sdaSync_ff, sdaDly_ff;
  logic startDet, stopDet, sclRise, sclFall;
  i2cr_pkg::i2cr_state_e state_ff, nxt_state;
  i2cr_pkg::i2cr_phase_e phase_ff, nxt_phase;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr;
  logic ackFlag_ff, nxt_ackFlag;
  logic rw_ff, nxt_rw;
  logic oe_n_ff, nxt_oe_n;
  logic busy_ff, nxt_busy;
  i2cr_pkg::i2cr_regreq_s regReq_ff, nxt_regReq;
  logic [7:0] cfg0_ff, cfg1_ff;
  logic [7:0] rdByte;
  logic addrMatch;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] nextReadPtr(
    input logic [7:0] ptr,
    input logic en0,
    input logic en1
  );
    logic [7:0] res;
    res = ptr + i2cr_pkg::PTR_STEP;
    if (en0 && !en1 && ptr == i2cr_pkg::SENSOR0_RESULT_HIGH) begin
      res = i2cr_pkg::DEVICE_STATUS_MIRROR;
    end
    if (!en0 && en1 && ptr == i2cr_pkg::SENSOR1_RESULT_HIGH) begin
      res = i2cr_pkg::DEVICE_STATUS_MIRROR;
    end
    if (en0 && en1 && ptr == i2cr_pkg::SENSOR0_TIMESTAMP_BYTE3) begin
      res = i2cr_pkg::DEVICE_STATUS_MIRROR;
    end
    return res;
  endfunction : nextReadPtr

  function automatic logic [7:0] readByte(
    input logic [7:0] addr,
    input logic [7:0] c0,
    input logic [7:0] c1,
    input logic [7:0] core
  );
    logic [7:0] res;
    res = core;
    if (addr == i2cr_pkg::SOURCE_SLOT0_CONFIG) begin
      res = c0;
    end
    if (addr == i2cr_pkg::SOURCE_SLOT1_CONFIG) begin
      res = c1;
    end
    return res;
  endfunction : readByte

  // ---------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclMeta_ff <= 1'b1;
      sclSync_ff <= 1'b1;
      sclDly_ff <= 1'b1;
    end else begin
      sclMeta_ff <= scl;
      sclSync_ff <= sclMeta_ff;
      sclDly_ff <= sclSync_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaMeta_ff <= 1'b1;
      sdaSync_ff <= 1'b1;
      sdaDly_ff <= 1'b1;
    end else begin
      sdaMeta_ff <= sdaIn;
      sdaSync_ff <= sdaMeta_ff;
      sdaDly_ff <= sdaSync_ff;
    end
  end

  // sda edges only count while scl stays high
  assign startDet = sclSync_ff & sclDly_ff & sdaDly_ff & ~sdaSync_ff;
  assign stopDet = sclSync_ff & sclDly_ff & ~sdaDly_ff & sdaSync_ff;
  assign sclRise = sclSync_ff & ~sclDly_ff;
  assign sclFall = ~sclSync_ff & sclDly_ff;

  assign rdByte = readByte(ptr_ff, cfg0_ff, cfg1_ff, regRdData);
  assign addrMatch = (shift_ff[7:1] == CLIENT_ADDR);

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_ackFlag = ackFlag_ff;
    nxt_rw = rw_ff;
    nxt_oe_n = oe_n_ff;
    nxt_busy = busy_ff;
    nxt_regReq = regReq_ff;
    nxt_regReq.wr = 1'b0;
    if (stopDet) begin
      nxt_state = i2cr_pkg::ST_IDLE;
      nxt_busy = 1'b0;
      nxt_oe_n = 1'b1;
    end else if (startDet) begin
      // plain and repeated start take the same path
      nxt_state = i2cr_pkg::ST_RX;
      nxt_phase = i2cr_pkg::PH_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_busy = 1'b1;
      nxt_oe_n = 1'b1;
      nxt_rw = 1'b0;
    end else begin
      case (state_ff)
        i2cr_pkg::ST_IDLE: begin
          // wait for stop or restart after a nack
          nxt_oe_n = 1'b1;
        end
        i2cr_pkg::ST_RX: begin
          if (sclRise) begin
            nxt_shift = {shift_ff[6:0], sdaSync_ff};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (sclFall && bitCnt_ff == i2cr_pkg::BITS_PER_BYTE) begin
            nxt_state = i2cr_pkg::ST_ACK;
            nxt_bitCnt = 4'h0;
            case (phase_ff)
              i2cr_pkg::PH_ADDR: begin
                nxt_ackFlag = addrMatch & deviceReady;
                nxt_rw = shift_ff[0];
                nxt_phase = i2cr_pkg::PH_PTR;
              end
              i2cr_pkg::PH_PTR: begin
                nxt_ackFlag = 1'b1;
                nxt_ptr = shift_ff;
                nxt_phase = i2cr_pkg::PH_DATA;
              end
              i2cr_pkg::PH_DATA: begin
                nxt_ackFlag = 1'b1;
                nxt_regReq.wr = 1'b1;
                nxt_regReq.addr = ptr_ff;
                nxt_regReq.data = shift_ff;
                nxt_ptr = ptr_ff + i2cr_pkg::PTR_STEP;
              end
              default: begin
                nxt_ackFlag = 1'b0;
              end
            endcase
            nxt_oe_n = ~nxt_ackFlag;
          end
        end
        i2cr_pkg::ST_ACK: begin
          if (sclFall) begin
            nxt_bitCnt = 4'h0;
            if (!ackFlag_ff) begin
              nxt_state = i2cr_pkg::ST_IDLE;
              nxt_oe_n = 1'b1;
            end else if (rw_ff) begin
              nxt_state = i2cr_pkg::ST_TX;
              nxt_shift = rdByte;
              nxt_oe_n = rdByte[7];
            end else begin
              nxt_state = i2cr_pkg::ST_RX;
              nxt_oe_n = 1'b1;
            end
          end
        end
        i2cr_pkg::ST_TX: begin
          if (sclRise) begin
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_ff == i2cr_pkg::BITS_PER_BYTE) begin
              nxt_state = i2cr_pkg::ST_TXACK;
              nxt_oe_n = 1'b1;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe_n = shift_ff[6];
            end
          end
        end
        i2cr_pkg::ST_TXACK: begin
          if (sclRise) begin
            nxt_ackFlag = ~sdaSync_ff;
            if (!sdaSync_ff) begin
              nxt_ptr = nextReadPtr(ptr_ff,
                cfg0_ff[i2cr_pkg::SOURCE_WRAP_ENABLE_BIT],
                cfg1_ff[i2cr_pkg::SOURCE_WRAP_ENABLE_BIT]);
            end
          end else if (sclFall) begin
            nxt_bitCnt = 4'h0;
            if (ackFlag_ff) begin
              // next byte fetched inside the ack pulse
              nxt_state = i2cr_pkg::ST_TX;
              nxt_shift = rdByte;
              nxt_oe_n = rdByte[7];
            end else begin
              nxt_state = i2cr_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          nxt_state = i2cr_pkg::ST_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= i2cr_pkg::ST_IDLE;
      phase_ff <= i2cr_pkg::PH_ADDR;
      bitCnt_ff <= 4'h0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      bitCnt_ff <= nxt_bitCnt;
      busy_ff <= nxt_busy;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= 8'h00;
      ackFlag_ff <= 1'b0;
      rw_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      shift_ff <= nxt_shift;
      ackFlag_ff <= nxt_ackFlag;
      rw_ff <= nxt_rw;
      oe_n_ff <= nxt_oe_n;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_ff <= i2cr_pkg::PTR_RST;
      regReq_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
      regReq_ff <= nxt_regReq;
    end
  end

  // ---------------------------------------------------------------
  // source slot configuration copies
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg0_ff <= i2cr_pkg::SOURCE_SLOT_CONFIG_RST;
      cfg1_ff <= i2cr_pkg::SOURCE_SLOT_CONFIG_RST;
    end else if (regReq_ff.wr) begin
      if (regReq_ff.addr == i2cr_pkg::SOURCE_SLOT0_CONFIG) begin
        cfg0_ff <= regReq_ff.data;
      end
      if (regReq_ff.addr == i2cr_pkg::SOURCE_SLOT1_CONFIG) begin
        cfg1_ff <= regReq_ff.data;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // scl is only ever an input: no stretching, client only
  assign sdaOut = 1'b0;
  assign sdaOe_n = oe_n_ff;
  assign busy = busy_ff;
  assign regAddr = ptr_ff;
  assign regReq = regReq_ff;
  assign sourceSlot0Config = cfg0_ff;
  assign sourceSlot1Config = cfg1_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_start_busy;
    startDet && !stopDet |=> busy && state_ff == i2cr_pkg::ST_RX;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not make bus busy");

  property p_restart;
    busy && startDet |=> bitCnt_ff == 4'h0 && sdaOe_n &&
      phase_ff == i2cr_pkg::PH_ADDR;
  endproperty
  a_restart: assert property (p_restart)
    else $error("repeated start not handled as start");

  property p_stop_free;
    stopDet |=> !busy && state_ff == i2cr_pkg::ST_IDLE && sdaOe_n;
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("stop did not free the bus");

  property p_sda_stable;
    sclSync_ff && $past(sclSync_ff) |-> $stable(sdaOe_n);
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("sda drive changed while scl high");

  property p_ack_drive;
    state_ff == i2cr_pkg::ST_ACK && sclSync_ff |-> sdaOe_n == !ackFlag_ff;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("ack slot drive wrong");

  property p_nack_mismatch;
    state_ff == i2cr_pkg::ST_RX && phase_ff == i2cr_pkg::PH_ADDR &&
      sclFall && bitCnt_ff == 4'h8 && !(addrMatch && deviceReady)
      |=> sdaOe_n [*2];
  endproperty
  a_nack_mismatch: assert property (p_nack_mismatch)
    else $error("no nack for foreign address");

  property p_write_inc;
    regReq.wr |-> ptr_ff == regReq.addr + 8'h01 && $past(busy);
  endproperty
  a_write_inc: assert property (p_write_inc)
    else $error("pointer not advanced after write");

  property p_wrap_src0;
    state_ff == i2cr_pkg::ST_TXACK && sclRise && !sdaSync_ff &&
      cfg0_ff[7] && !cfg1_ff[7] && ptr_ff == 8'h63 |=> ptr_ff == 8'h61;
  endproperty
  a_wrap_src0: assert property (p_wrap_src0)
    else $error("source0 wrap missed");

  property p_wrap_both;
    state_ff == i2cr_pkg::ST_TXACK && sclRise && !sdaSync_ff &&
      cfg0_ff[7] && cfg1_ff[7] && ptr_ff == 8'h69 |=> ptr_ff == 8'h61;
  endproperty
  a_wrap_both: assert property (p_wrap_both)
    else $error("dual source wrap missed");

  property p_roll;
    state_ff == i2cr_pkg::ST_TXACK && sclRise && !sdaSync_ff &&
      !cfg0_ff[7] && !cfg1_ff[7] |=> ptr_ff == $past(ptr_ff) + 8'h01;
  endproperty
  a_roll: assert property (p_roll)
    else $error("plain increment wrong");

  property p_read_nack_hold;
    state_ff == i2cr_pkg::ST_TXACK && sclRise && sdaSync_ff
      |=> $stable(ptr_ff);
  endproperty
  a_read_nack_hold: assert property (p_read_nack_hold)
    else $error("pointer moved on host nack");

  c_write: cover property (regReq.wr);
  c_read: cover property (state_ff == i2cr_pkg::ST_TX);
  c_wrap: cover property (state_ff == i2cr_pkg::ST_TXACK &&
    $changed(ptr_ff) && ptr_ff == 8'h61);
  c_nack: cover property (state_ff == i2cr_pkg::ST_ACK && !ackFlag_ff);

endmodule : i2cr_client_port

`default_nettype wire

// file: verilog/i2cr_pkg.sv
// Overview of operation
// - client only, standard, fast and fast-plus rates
// - sample SDA at SCL high, change low
// - START is SDA falling, bus busy
// - repeated START handled like plain START
// - STOP is SDA rising, bus free
// - whole bytes, MSB first, unlimited count
// - no clock stretching, work done in ack
// - receiver holds SDA low on ack pulse
// - NACK on mismatch, not ready, refusal
// - write is address, pointer, data, STOP
// - pointer plus one after each written byte
// - read is pointer, restart, address, data, NACK
// - no enables, pointer rolls FFh to 00h
// - source0 only, wrap 63h back to 61h
// - source1 only, wrap 65h back to 61h
// - both enables, wrap 69h back to 61h
// - enable bits live in 1Ah and 1Bh
`default_nettype none

package i2cr_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SIGNAL_PROCESSOR_STATUS = 8'h60;
  localparam logic [7:0] DEVICE_STATUS_MIRROR = 8'h61;
  localparam logic [7:0] SENSOR0_RESULT_HIGH = 8'h63;
  localparam logic [7:0] SENSOR1_RESULT_HIGH = 8'h65;
  localparam logic [7:0] SENSOR0_TIMESTAMP_BYTE3 = 8'h69;
  localparam logic [7:0] SOURCE_SLOT0_CONFIG = 8'h1A;
  localparam logic [7:0] SOURCE_SLOT1_CONFIG = 8'h1B;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int SOURCE_WRAP_ENABLE_BIT = 7;
  localparam logic [7:0] SOURCE_SLOT_CONFIG_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TXACK = 5'h10
  } i2cr_state_e;

  typedef enum logic [2:0] {
    PH_ADDR = 3'h1,
    PH_PTR = 3'h2,
    PH_DATA = 3'h4
  } i2cr_phase_e;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } i2cr_regreq_s;

endpackage : i2cr_pkg

`default_nettype wire
